// >>> logic/dcs_defines.svh
/*
 Register offsets, field positions, reset values and fixed counts of the clock synth core.
 Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// ============================================================
// Register byte offsets
`define DCS_OFF_CTRL1      12'h000
`define DCS_OFF_CTRL2      12'h004
`define DCS_OFF_PROF_IDX   12'h008
`define DCS_OFF_PROF_FTWL  12'h00C
`define DCS_OFF_PROF_FTWH  12'h010
`define DCS_OFF_PROF_PHASE 12'h014
`define DCS_OFF_PROF_LOAD  12'h018
`define DCS_OFF_STATUS     12'h01C

// ============================================================
// First control word fields
`define DCS_C1_HS_SYNC     0
`define DCS_C1_HW_SYNC     1
`define DCS_C1_AUTO_SYNC   3
`define DCS_C1_LOCK_ERR    24
`define DCS_C1_WMASK       32'h0000000B
`define DCS_C1_RESET       32'h00000000

// ============================================================
// Second control word fields
`define DCS_C2_CP_LSB      0
`define DCS_C2_RDIV_LSB    3
`define DCS_C2_SYS_UNDIV   5
`define DCS_C2_DRV_LSB     6
`define DCS_C2_M_LSB       8
`define DCS_C2_N_LSB       12
`define DCS_C2_SURGE_RISE  16
`define DCS_C2_SURGE_FALL  17
`define DCS_C2_NODEF_RISE  18
`define DCS_C2_NODEF_FALL  19
`define DCS_C2_WMASK       32'h000FFFFF
`define DCS_C2_RESET       32'h00000000

// ============================================================
// Driver source codes
`define DCS_DRV_UNDIV      2'h0
`define DCS_DRV_DIV        2'h1
`define DCS_DRV_FEEDBACK   2'h2

// ============================================================
// Sizes and alignment counts
`define DCS_ACC_W          48
`define DCS_PHASE_W        14
`define DCS_DAC_W          10
`define DCS_PROF_W         62
`define DCS_ALIGN_CNT_LS   2'h1
`define DCS_ALIGN_CNT_HS   2'h2
`define DCS_DAC_MID        11'h200
`define DCS_DAC_MAX        11'h3FF

`endif

// >>> logic/dcs_pkg.sv
/*
 Types shared by the clock synth core.
 Assumes dcs_defines.svh for all numeric constants.
*/
package dcs_pkg;
    // ============================================================
    // Sync clock alignment modes
    typedef enum logic [1:0] {
        DCS_SYNC_FREE,
        DCS_SYNC_MANUAL,
        DCS_SYNC_AUTO
    } dcs_sync_mode_t;

    typedef logic [2:0] dcs_prof_idx_t;
endpackage : dcs_pkg

// >>> logic/dcs_profile_mem.sv
/*
 Eight-entry profile store; each word holds a phase offset above a frequency word.
 Assumes one write port from the register block and a read address already synchronised.
*/
`timescale 1ns/1ps
`include "dcs_defines.svh"

module dcs_profile_mem
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_we,
    input wire dcs_pkg::dcs_prof_idx_t i_waddr,
    input wire logic [`DCS_PROF_W-1:0] i_wdata,
    input wire dcs_pkg::dcs_prof_idx_t i_raddr,
    output logic [`DCS_PROF_W-1:0] o_rdata
);
    import dcs_pkg::*;

    logic [`DCS_PROF_W-1:0] mem_r [0:7];
    logic [`DCS_PROF_W-1:0] rdata_r;

    // ============================================================
    // Storage
    // Both fields leave in one registered word, so a profile change can never mix two entries.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_ce && i_we)
        begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            rdata_r <= '0;
        end
        else if (i_ce)
        begin
            rdata_r <= mem_r[i_raddr];
        end
    end

    assign o_rdata = rdata_r;
endmodule : dcs_profile_mem

// >>> logic/dcs_core.sv
/*
 Digital core of the DDS clock synthesiser: control words, profiles, phase path,
 cosine amplitude and sync clock alignment, with an APB register slave.
 Assumes i_ref_clk is the DDS sample clock; profile pins, sync input and lock error
 arrive asynchronously; the analog dividers and driver take the control outputs.
*/
`timescale 1ns/1ps
`include "dcs_defines.svh"

module dcs_core
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire dcs_pkg::dcs_prof_idx_t i_profile_select,
    input wire logic i_sync_in,
    input wire logic i_lock_err,
    output logic o_status_out,
    output logic o_status_oe_n,
    output logic o_sync_clk,
    output logic [`DCS_DAC_W-1:0] o_dac_data,
    output logic [1:0] o_rf_div_code,
    output logic o_dds_sample_clock_undivided,
    output logic [1:0] o_driver_src,
    output logic [3:0] o_ref_div_m1,
    output logic [3:0] o_fb_div_n1,
    output logic [2:0] o_cp_scale_m1,
    output logic o_surge_rise_extra,
    output logic o_surge_fall_extra,
    output logic o_surge_rise_def_off,
    output logic o_surge_fall_def_off
);
    import dcs_pkg::*;

    // ============================================================
    // Input synchronisers
    logic [2:0] prof_s1_r, prof_s2_r;
    logic sync_s1_r, sync_s2_r, sync_s3_r;
    logic lock_s1_r, lock_s2_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            prof_s1_r <= 3'h0;
            prof_s2_r <= 3'h0;
            sync_s1_r <= 1'b0;
            sync_s2_r <= 1'b0;
            sync_s3_r <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end
        else if (i_ce)
        begin
            prof_s1_r <= i_profile_select;
            prof_s2_r <= prof_s1_r;
            sync_s1_r <= i_sync_in;
            sync_s2_r <= sync_s1_r;
            sync_s3_r <= sync_s2_r;
            lock_s1_r <= i_lock_err;
            lock_s2_r <= lock_s1_r;
        end
    end

    logic sync_rise;
    assign sync_rise = sync_s2_r && !sync_s3_r;
    // ============================================================
    // Register block
    logic [31:0] ctrl1_r, ctrl1_nxt;
    logic [31:0] ctrl2_r, ctrl2_nxt;
    logic [2:0] pidx_r, pidx_nxt;
    logic [31:0] pftwl_r, pftwl_nxt;
    logic [15:0] pftwh_r, pftwh_nxt;
    logic [13:0] pphase_r, pphase_nxt;
    logic lock_err_r, lock_err_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic prof_we;
    logic [1:0] sync_cnt_r, sync_cnt_nxt;
    logic [1:0] drv_r, drv_nxt;

    logic setup_ph, wr_ph;
    assign setup_ph = i_psel && !i_penable;
    assign wr_ph = i_psel && i_penable && pready_r && i_pwrite;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `DCS_OFF_CTRL1) || (a == `DCS_OFF_CTRL2) ||
                  (a == `DCS_OFF_PROF_IDX) || (a == `DCS_OFF_PROF_FTWL) ||
                  (a == `DCS_OFF_PROF_FTWH) || (a == `DCS_OFF_PROF_PHASE) ||
                  (a == `DCS_OFF_PROF_LOAD) || (a == `DCS_OFF_STATUS);
    endfunction : addr_ok
    always_comb
    begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        pidx_nxt = pidx_r;
        pftwl_nxt = pftwl_r;
        pftwh_nxt = pftwh_r;
        pphase_nxt = pphase_r;
        lock_err_nxt = lock_err_r;
        prdata_nxt = prdata_r;
        pready_nxt = setup_ph;
        pslverr_nxt = setup_ph && !addr_ok(i_paddr);
        prof_we = 1'b0;
        if (setup_ph)
        begin
            prdata_nxt = 32'h0;
            case (i_paddr)
                `DCS_OFF_CTRL1: prdata_nxt = ctrl1_r | ({31'h0, lock_err_r} << `DCS_C1_LOCK_ERR);
                `DCS_OFF_CTRL2: prdata_nxt = ctrl2_r;
                `DCS_OFF_PROF_IDX: prdata_nxt = {29'h0, pidx_r};
                `DCS_OFF_PROF_FTWL: prdata_nxt = pftwl_r;
                `DCS_OFF_PROF_FTWH: prdata_nxt = {16'h0, pftwh_r};
                `DCS_OFF_PROF_PHASE: prdata_nxt = {18'h0, pphase_r};
                `DCS_OFF_STATUS: prdata_nxt = {25'h0, lock_s2_r, sync_s2_r, sync_cnt_r, prof_s2_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
        if (wr_ph)
        begin
            case (i_paddr)
                `DCS_OFF_CTRL1:
                begin
                    ctrl1_nxt = i_pwdata & `DCS_C1_WMASK;
                    lock_err_nxt = lock_err_r && !i_pwdata[`DCS_C1_LOCK_ERR];
                end
                `DCS_OFF_CTRL2: ctrl2_nxt = i_pwdata & `DCS_C2_WMASK;
                `DCS_OFF_PROF_IDX: pidx_nxt = i_pwdata[2:0];
                `DCS_OFF_PROF_FTWL: pftwl_nxt = i_pwdata;
                `DCS_OFF_PROF_FTWH: pftwh_nxt = i_pwdata[15:0];
                `DCS_OFF_PROF_PHASE: pphase_nxt = i_pwdata[13:0];
                `DCS_OFF_PROF_LOAD: prof_we = 1'b1;
                default: prof_we = 1'b0;
            endcase
        end
        // A lock error in the same cycle as its clear wins, so no event is lost.
        lock_err_nxt = lock_err_nxt || lock_s2_r;
        drv_nxt = (ctrl2_nxt[`DCS_C2_DRV_LSB +: 2] == `DCS_DRV_FEEDBACK) ?
                  `DCS_DRV_FEEDBACK : {1'b0, ctrl2_nxt[`DCS_C2_DRV_LSB]};
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            ctrl1_r <= `DCS_C1_RESET;
            ctrl2_r <= `DCS_C2_RESET;
            pidx_r <= 3'h0;
            pftwl_r <= 32'h0;
            pftwh_r <= 16'h0;
            pphase_r <= 14'h0;
            lock_err_r <= 1'b0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            drv_r <= `DCS_DRV_UNDIV;
        end
        else if (i_ce)
        begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            pidx_r <= pidx_nxt;
            pftwl_r <= pftwl_nxt;
            pftwh_r <= pftwh_nxt;
            pphase_r <= pphase_nxt;
            lock_err_r <= lock_err_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            drv_r <= drv_nxt;
        end
    end
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;

    // ============================================================
    // Analog control fields
    // The analog dividers and scaler take these codes directly from the second word; the driver code is registered with 3 mapped to 1.
    assign o_rf_div_code = ctrl2_r[`DCS_C2_RDIV_LSB +: 2];
    assign o_dds_sample_clock_undivided = ctrl2_r[`DCS_C2_SYS_UNDIV];
    assign o_driver_src = drv_r;
    assign o_ref_div_m1 = ctrl2_r[`DCS_C2_M_LSB +: 4];
    assign o_fb_div_n1 = ctrl2_r[`DCS_C2_N_LSB +: 4];
    assign o_cp_scale_m1 = ctrl2_r[`DCS_C2_CP_LSB +: 3];
    assign o_surge_rise_extra = ctrl2_r[`DCS_C2_SURGE_RISE];
    assign o_surge_fall_extra = ctrl2_r[`DCS_C2_SURGE_FALL];
    assign o_surge_rise_def_off = ctrl2_r[`DCS_C2_NODEF_RISE];
    assign o_surge_fall_def_off = ctrl2_r[`DCS_C2_NODEF_FALL];

    // ============================================================
    // Profile store
    logic [`DCS_PROF_W-1:0] prof_word;

    dcs_profile_mem u_prof
    (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_we(prof_we),
        .i_waddr(pidx_r),
        .i_wdata({pphase_r, pftwh_r, pftwl_r}),
        .i_raddr(prof_s2_r),
        .o_rdata(prof_word)
    );

    // ============================================================
    // Phase path and amplitude
    logic [`DCS_ACC_W-1:0] acc_r, acc_nxt;
    logic [`DCS_PHASE_W-1:0] poff_r, poff_nxt;
    logic [`DCS_PHASE_W-1:0] phase_r, phase_nxt;
    logic [`DCS_DAC_W-1:0] dac_r, dac_nxt;
    logic [9:0] q, y;
    logic [8:0] x;
    logic [18:0] prod;
    logic [10:0] amp;

    always_comb
    begin
        acc_nxt = acc_r + prof_word[`DCS_ACC_W-1:0];
        poff_nxt = prof_word[`DCS_PROF_W-1:`DCS_ACC_W];
        // The offset registered beside the accumulator keeps both from one profile.
        phase_nxt = acc_r[`DCS_ACC_W-1 -: `DCS_PHASE_W] + poff_r;
        // Cosine is a sine a quarter turn ahead; a parabola per half cycle keeps the
        // lookup small at the cost of under six percent amplitude error.
        q = phase_r[`DCS_PHASE_W-1 -: 10] + 10'h100;
        x = q[8:0];
        prod = {10'h0, x} * (19'h00200 - {10'h0, x});
        y = (prod[16:7] > 10'h1FF) ? 10'h1FF : prod[16:7];
        amp = q[9] ? (`DCS_DAC_MID - {1'b0, y}) : (`DCS_DAC_MID + {1'b0, y});
        dac_nxt = (amp > `DCS_DAC_MAX) ? 10'(`DCS_DAC_MAX) : amp[9:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            acc_r <= '0;
            poff_r <= '0;
            phase_r <= '0;
            dac_r <= '0;
        end
        else if (i_ce)
        begin
            acc_r <= acc_nxt;
            poff_r <= poff_nxt;
            phase_r <= phase_nxt;
            dac_r <= dac_nxt;
        end
    end
    assign o_dac_data = dac_r;

    // ============================================================
    // Sync clock generation and alignment
    dcs_sync_mode_t mode;
    logic sync_clk_r, sync_clk_nxt;
    logic stat_r, stat_nxt;
    logic stat_oe_n_r, stat_oe_n_nxt;

    always_comb
    begin
        mode = ctrl1_r[`DCS_C1_AUTO_SYNC] ? DCS_SYNC_AUTO :
               (ctrl1_r[`DCS_C1_HW_SYNC] ? DCS_SYNC_MANUAL : DCS_SYNC_FREE);
        sync_cnt_nxt = sync_cnt_r + 2'h1;
        case (mode)
            DCS_SYNC_MANUAL:
                sync_cnt_nxt = sync_rise ? sync_cnt_r + 2'h2 : sync_cnt_r + 2'h1;
            DCS_SYNC_AUTO:
            begin
                // The alignment count absorbs the synchroniser delay; the fast mode
                // assumes one more cycle of input path latency.
                if (sync_rise)
                begin
                    sync_cnt_nxt = ctrl1_r[`DCS_C1_HS_SYNC] ?
                                   `DCS_ALIGN_CNT_HS : `DCS_ALIGN_CNT_LS;
                end
            end
            default: sync_cnt_nxt = sync_cnt_r + 2'h1;
        endcase
        sync_clk_nxt = sync_cnt_r[1];
        stat_oe_n_nxt = (mode != DCS_SYNC_FREE);
        stat_nxt = lock_s2_r && (mode == DCS_SYNC_FREE);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            sync_cnt_r <= 2'h0;
            sync_clk_r <= 1'b0;
            stat_r <= 1'b0;
            stat_oe_n_r <= 1'b0;
        end
        else if (i_ce)
        begin
            sync_cnt_r <= sync_cnt_nxt;
            sync_clk_r <= sync_clk_nxt;
            stat_r <= stat_nxt;
            stat_oe_n_r <= stat_oe_n_nxt;
        end
    end
    assign o_sync_clk = sync_clk_r;
    assign o_status_out = stat_r;
    assign o_status_oe_n = stat_oe_n_r;
endmodule : dcs_core

// >>> verif/dcs_core_props.sv
/*
 Concurrent checks on the ports of dcs_core.
 Assumes one clock domain, a synchronous active-low reset and i_ce held high.
*/
`timescale 1ns/1ps
`include "dcs_defines.svh"

module dcs_core_props
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_lock_err,
    input wire logic o_status_out,
    input wire logic o_status_oe_n,
    input wire logic o_sync_clk,
    input wire logic [1:0] o_rf_div_code,
    input wire logic o_dds_sample_clock_undivided,
    input wire logic [1:0] o_driver_src,
    input wire logic [3:0] o_ref_div_m1,
    input wire logic [3:0] o_fb_div_n1,
    input wire logic [2:0] o_cp_scale_m1,
    input wire logic o_surge_rise_extra,
    input wire logic o_surge_fall_extra,
    input wire logic o_surge_rise_def_off,
    input wire logic o_surge_fall_def_off
);
    // ============================================================
    // Free-run tracker
    // The divider is only judged once the sync modes have been off a while,
    // because leaving a mode may still shift the phase once.
    logic [3:0] free_cnt_r;
    logic [3:0] free_cnt_nxt;
    logic free;

    always_comb
    begin
        free_cnt_nxt = free_cnt_r;
        if (o_status_oe_n)
            free_cnt_nxt = 4'h0;
        else if (free_cnt_r != 4'hF)
            free_cnt_nxt = free_cnt_r + 4'h1;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
            free_cnt_r <= 4'h0;
        else
            free_cnt_r <= free_cnt_nxt;
    end

    assign free = free_cnt_r > 4'h8;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    // ============================================================
    // Assertions
    sequence s_c2_wr;
        i_psel && i_penable && o_pready && i_pwrite && i_ce && i_paddr == `DCS_OFF_CTRL2;
    endsequence

    a_ctrl2_fields: assert property (s_c2_wr |=>
        {o_surge_fall_def_off, o_surge_rise_def_off, o_surge_fall_extra, o_surge_rise_extra,
        o_fb_div_n1, o_ref_div_m1, o_dds_sample_clock_undivided, o_rf_div_code, o_cp_scale_m1}
        == {$past(i_pwdata[19:8]), $past(i_pwdata[5:0])})
        else $error("control word fields do not follow the write");
    a_driver_src: assert property (s_c2_wr |=> o_driver_src ==
        (($past(i_pwdata[7:6]) == 2'h3) ? 2'h1 : $past(i_pwdata[7:6])))
        else $error("driver source code wrong");
    a_sync_div4: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn || o_status_oe_n)
        free && $rose(o_sync_clk) |=> o_sync_clk ##1 !o_sync_clk [*2] ##1 o_sync_clk)
        else $error("sync clock is not a divide by four");
    a_status_quiet: assert property (o_status_oe_n |-> !o_status_out)
        else $error("status driven while sync pin is an input");
    a_lock_status: assert property (free && $rose(i_lock_err) |->
        ##[1:5] o_status_out)
        else $error("lock error not shown on status");
    a_pready_answer: assert property (i_psel && !i_penable && i_ce |=> o_pready)
        else $error("no ready in the access cycle");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready stands longer than one cycle");
    a_err_zero: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0)
        else $error("refused read not zero or without ready");

    c_err: cover property (o_pslverr);
    c_lock: cover property (o_status_out);
    c_free: cover property (free && $rose(o_sync_clk));
    c_mode: cover property (o_status_oe_n && $rose(o_sync_clk));
endmodule : dcs_core_props

bind dcs_core dcs_core_props u_props (.i_ref_clk, .i_rstn, .i_ce, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_lock_err,
    .o_status_out, .o_status_oe_n, .o_sync_clk, .o_rf_div_code, .o_dds_sample_clock_undivided,
    .o_driver_src, .o_ref_div_m1, .o_fb_div_n1, .o_cp_scale_m1, .o_surge_rise_extra,
    .o_surge_fall_extra, .o_surge_rise_def_off, .o_surge_fall_def_off);

// >>> verif/dcs_far_model.sv
/*
 Far side of the core: profile pins, a peer master sync clock and a lock detector.
 Assumes requests from the bench change right after a rising edge.
*/
`timescale 1ns/1ps

module dcs_far_model
(
    input wire logic i_ref_clk,
    input wire logic i_master_on,
    input wire logic i_pulse,
    input wire dcs_pkg::dcs_prof_idx_t i_sel,
    input wire logic i_lock,
    output dcs_pkg::dcs_prof_idx_t o_profile_select,
    output logic o_sync_in,
    output logic o_lock_err
);
    import dcs_pkg::*;
    logic [1:0] ph_r;
    logic [2:0] hold_r;

    initial
    begin
        ph_r = 2'h0;
        hold_r = 3'h0;
        o_profile_select = 3'h0;
        o_sync_in = 1'b0;
        o_lock_err = 1'b0;
    end

    // A single edge is held four cycles so that it survives the input synchroniser.
    always @(posedge i_ref_clk)
    begin
        ph_r <= ph_r + 2'h1;
        o_profile_select <= i_sel;
        o_lock_err <= i_lock;
        hold_r <= i_pulse ? 3'h4 : ((hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0);
        o_sync_in <= i_master_on ? ph_r[1] : (hold_r != 3'h0);
    end
endmodule : dcs_far_model

// >>> verif/testbench.sv
/*
 Self-checking bench for dcs_core with an APB master and a shadow model.
 Assumes the checker is bound and the far-side model drives the pins.
*/
`timescale 1ns/1ps
`include "dcs_defines.svh"

module testbench;
    import dcs_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_status_out, o_status_oe_n, o_sync_clk, o_dds_sample_clock_undivided;
    logic o_surge_rise_extra, o_surge_fall_extra, o_surge_rise_def_off, o_surge_fall_def_off;
    logic [9:0] o_dac_data;
    logic [1:0] o_rf_div_code, o_driver_src;
    logic [3:0] o_ref_div_m1, o_fb_div_n1;
    logic [2:0] o_cp_scale_m1;
    dcs_prof_idx_t i_profile_select, sel = 3'h0;
    logic i_sync_in, i_lock_err, master_on = 1'b0, pulse = 1'b0, lock_req = 1'b0;
    logic [31:0] r, d;
    logic er;
    logic [9:0] q0, q1, q2;
    int cyc = 0, checks = 0, miscompares = 0, i, p0, p1, pa, c1m, c2m;
    int cosq[8] = '{511, 361, 0, -361, -511, -361, 0, 361};

    always #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;

    dcs_core dut (.i_ref_clk, .i_rstn, .i_ce(1'b1), .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_profile_select, .i_sync_in,
        .i_lock_err, .o_status_out, .o_status_oe_n, .o_sync_clk, .o_dac_data, .o_rf_div_code,
        .o_dds_sample_clock_undivided, .o_driver_src, .o_ref_div_m1, .o_fb_div_n1, .o_cp_scale_m1,
        .o_surge_rise_extra, .o_surge_fall_extra, .o_surge_rise_def_off, .o_surge_fall_def_off);
    dcs_far_model far (.i_ref_clk, .i_master_on(master_on), .i_pulse(pulse), .i_sel(sel),
        .i_lock(lock_req), .o_profile_select(i_profile_select), .o_sync_in(i_sync_in),
        .o_lock_err(i_lock_err));

    // ============================================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e,
        input int tol = 0);
        checks++;
        if ((^s === 1'bx) || (((s > e) ? s - e : e - s) > tol))
        begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd_o, output logic err_o);
        int k;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge i_ref_clk);
            if (o_pready === 1'b1)
                break;
        end
        if (k == 16)
        begin
            miscompares++;
            tally_and_finish();
        end
        rd_o = o_prdata;
        err_o = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, r, er);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0, r, er);
        chk(n, r, e);
    endtask : rd

    // Returns the cycle phase, modulo four, of the next sync clock rise.
    task automatic phase(output int p);
        int k;
        logic q;
        q = o_sync_clk;
        for (k = 0; k < 12; k++)
        begin
            @(posedge i_ref_clk);
            if (q === 1'b0 && o_sync_clk === 1'b1)
                break;
            q = o_sync_clk;
        end
        if (k == 12)
        begin
            miscompares++;
            tally_and_finish();
        end
        p = cyc % 4;
    endtask : phase

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // Main sequence
    initial
    begin
        d = $urandom(32'hf446);
        repeat (8) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd(`DCS_OFF_CTRL1, `DCS_C1_RESET, "ctrl1");
        rd(`DCS_OFF_CTRL2, `DCS_C2_RESET, "ctrl2");
        rd(`DCS_OFF_PROF_LOAD, 32'h0, "load");
        $display("reset test done");
        for (i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 32'hFFFFFFFF : $urandom;
            d[7:6] = i[1:0];
            wr(`DCS_OFF_CTRL2, d);
            c2m = d & `DCS_C2_WMASK;
            rd(`DCS_OFF_CTRL2, c2m, "ctrl2");
            chk("rf div", o_rf_div_code, c2m[4:3]);
            chk("drv", o_driver_src, (c2m[7:6] == 3) ? 1 : c2m[7:6]);
            chk("ref div", o_ref_div_m1, c2m[11:8]);
            chk("fb div", o_fb_div_n1, c2m[15:12]);
            chk("cp", o_cp_scale_m1, c2m[2:0]);
        end
        apb(1'b1, 12'h020, 32'hFFFFFFFF, r, er);
        chk("err", er, 1'b1);
        apb(1'b0, 12'hFFC, 32'h0, r, er);
        chk("err", er, 1'b1);
        chk("err data", r, 32'h0);
        rd(`DCS_OFF_CTRL2, c2m, "ctrl2");
        $display("control test done");
        lock_req <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        chk("status", {o_status_oe_n, o_status_out}, 2'h1);
        apb(1'b0, `DCS_OFF_STATUS, 32'h0, r, er);
        chk("status reg", r & 32'h67, 32'h40);
        wr(`DCS_OFF_CTRL1, 32'h2);
        c1m = 32'h01000002;
        repeat (4) @(posedge i_ref_clk);
        chk("status", {o_status_oe_n, o_status_out}, 2'h2);
        lock_req <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
        rd(`DCS_OFF_CTRL1, c1m, "ctrl1");
        wr(`DCS_OFF_CTRL1, 32'h01000002);
        c1m = 32'h2;
        rd(`DCS_OFF_CTRL1, c1m, "ctrl1");
        $display("status test done");
        for (i = 0; i < 3; i++)
        begin
            phase(p0);
            @(posedge i_ref_clk);
            pulse <= 1'b1;
            @(posedge i_ref_clk);
            pulse <= 1'b0;
            repeat (12) @(posedge i_ref_clk);
            phase(p1);
            chk("advance", p1, (p0 + 3) % 4);
        end
        master_on <= 1'b1;
        wr(`DCS_OFF_CTRL1, 32'h8);
        repeat (16) @(posedge i_ref_clk);
        phase(pa);
        wr(`DCS_OFF_CTRL1, 32'h2);
        repeat (10) @(posedge i_ref_clk);
        wr(`DCS_OFF_CTRL1, 32'h8);
        repeat (16) @(posedge i_ref_clk);
        phase(p1);
        chk("align", p1, pa);
        wr(`DCS_OFF_CTRL1, 32'h9);
        repeat (16) @(posedge i_ref_clk);
        phase(p1);
        chk("align hs", p1, (pa + 3) % 4);
        chk("oe", o_status_oe_n, 1'b1);
        wr(`DCS_OFF_CTRL1, 32'h0);
        master_on <= 1'b0;
        $display("sync test done");
        for (i = 0; i < 8; i++)
        begin
            wr(`DCS_OFF_PROF_IDX, i);
            wr(`DCS_OFF_PROF_FTWL, 32'h0);
            wr(`DCS_OFF_PROF_FTWH, (i == 7) ? 32'h1000 : 32'h0);
            wr(`DCS_OFF_PROF_PHASE, i * 32'h800);
            wr(`DCS_OFF_PROF_LOAD, 32'h1);
        end
        rd(`DCS_OFF_PROF_PHASE, 32'h3800, "phase");
        // A reset clears the accumulator but keeps the stored profiles.
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            sel <= i;
            repeat (10) @(posedge i_ref_clk);
            chk("dac", o_dac_data, 512 + cosq[i], 40);
        end
        sel <= 3'h7;
        repeat (10) @(posedge i_ref_clk);
        for (i = 0; i < 4; i++)
        begin
            q0 = o_dac_data;
            repeat (8) @(posedge i_ref_clk);
            q1 = o_dac_data;
            repeat (8) @(posedge i_ref_clk);
            q2 = o_dac_data;
            chk("period", q2, q0);
            chk("half", 32'(q0) + 32'(q1), 1023, 40);
            @(posedge i_ref_clk);
        end
        $display("profile test done");
        tally_and_finish();
    end
endmodule : testbench
